/* File: shared/pbl_defines.vh */
// Purpose: Constants for the panel button and LED bar sequencer
// Assumes: 250 MHz system clock
// Notes: Times are in milliseconds; cycle counts derive from them
`ifndef PBL_DEFINES_VH
`define PBL_DEFINES_VH
`define PBL_CLK_HZ 250000000
`define PBL_MS_CYCLES (`PBL_CLK_HZ / 1000)
`define PBL_DEBOUNCE_MS 20
`define PBL_PWR_FIRST_MS 1500
`define PBL_PWR_ALL_MS 1000
`define PBL_HOLD_MS 1000
`define PBL_LASER_HOLD_MS 5000
`define PBL_RESULT_MS 2000
`define PBL_CONFIRM_TMO_MS 10000
`define PBL_STEP_MS 200
`define PBL_TWINKLE_MS 100
`define PBL_QFLASH_MS 100
`define PBL_FW_BLINK_MS 500
`define PBL_LED_OFF 5'h00
`define PBL_LED_ALL 5'h1F
`define PBL_LED_135 5'h15
`define PBL_LED_3 5'h04
`define PBL_LED_45 5'h18
`define PBL_LED_12 5'h03
`define PBL_LED_1245 5'h1B
`define PBL_LED_SWEEP_TOP 5'h10
`define PBL_LED_SWEEP_BOT 5'h01
`endif

/* File: hw/pbl_sequencer.v */
// Purpose: Front-panel button reader and five-LED bar sequencer
// Assumes: Buttons active high from pins; transfer engine and
//   measurement logic share sys_clk_in
// Notes: bar_led_out bit 0 is LED 1, bit 4 is LED 5
`timescale 1ns/100ps
`include "pbl_defines.vh"

// Operation
// [RL1] Power-up shows LEDs 3,5,1, then adds 2,4, then all off.
// [RL2] One quality flash per package; no flash on no-dimension result.
// [RL3] First press arms wait-for-confirm; all five LEDs twinkle fast.
// [RL4] Confirm sweeps LEDs: save 5 to 1, restore 1 to 5.
// [RL5] During transfer only LED 3 lit steadily yellow.
// [RL6] Success lights LEDs 4 and 5 green two seconds, then off.
// [RL7] Failure lights LEDs 1 and 2 red two seconds.
// [RL8] Firmware update: LEDs 1,2,4,5 on, LED 3 blinks.
// [RL9] Five-second laser hold toggles laser; all LEDs on, dark after.
// [RL10] Initiate needs hold of one second; twinkle starts on release.
// [RL11] Confirm is a press of same button shorter than one second.
// [RL12] A single press never starts save or restore.
// [RL13] Operator repeats both presses if no sweep appears.
// [RL14] Down arrow selects save; other arrow selects restore.
// [RL15] Disabled buttons start no action.
// [RL16] Laser button held at power-up selects recovery mode.
// [RL17] Operator unlocks module write protect before a save.
// [RL18] Missing confirm within timeout returns to idle.
// [RL19] Buttons debounced; durations timed by millisecond tick.
module pbl_sequencer #(
  parameter CONFIRM_TMO_MS = `PBL_CONFIRM_TMO_MS,
  parameter MS_CYCLES = `PBL_MS_CYCLES
) (
  input wire sys_clk_in,
  input wire reset_n_in,
  input wire btn_down_in,
  input wire btn_up_in,
  input wire btn_laser_in,
  input wire buttons_enable_in,
  input wire package_done_in,
  input wire no_dimension_result_in,
  input wire quality_good_in,
  input wire fw_update_in,
  input wire xfer_busy_in,
  input wire xfer_done_in,
  input wire xfer_ok_in,
  output reg [4:0] bar_led_out,
  output reg led_green_out,
  output reg led_red_out,
  output reg led_yellow_out,
  output reg xfer_start_out,
  output reg xfer_save_out,
  output reg laser_on_out,
  output reg recovery_mode_out
);
  localparam S_PWR1 = 4'd0;
  localparam S_PWR2 = 4'd1;
  localparam S_IDLE = 4'd2;
  localparam S_HOLD = 4'd3;
  localparam S_WAIT = 4'd4;
  localparam S_CONF = 4'd5;
  localparam S_SWEEP = 4'd6;
  localparam S_XFER = 4'd7;
  localparam S_OK = 4'd8;
  localparam S_FAIL = 4'd9;
  localparam S_LASER = 4'd10;
  localparam S_QFLASH = 4'd11;
  localparam S_REL = 4'd12;

  reg rst_s1_reg, rst_s2_reg;
  wire rst_n;
  reg [2:0] pin_s1_reg, pin_s2_reg;
  reg [2:0] btn_reg;
  reg [17:0] db_cnt_reg [0:2];
  reg [27:0] pre_reg;
  reg ms_tick_reg;
  reg [13:0] ms_cnt_reg;
  reg [3:0] state_reg;
  reg [2:0] step_reg;
  reg dir_save_reg;
  reg strap_done_reg;
  reg [6:0] blink_reg;
  reg fw_blink_reg;
  reg [8:0] fw_cnt_reg;
  reg tw_reg;
  reg q_good_reg;
  reg armed_btn_reg;
  wire any_btn;
  wire sel_btn;
  genvar gi;

  // Reset release through two flops
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign rst_n = rst_s2_reg;

  // Pin synchronisers; first stage feeds only the second
  always @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg <= 3'h0;
      pin_s2_reg <= 3'h0;
    end else begin
      pin_s1_reg <= {btn_laser_in, btn_up_in, btn_down_in};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // Millisecond tick from the system clock
  always @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg <= 28'h0000000;
      ms_tick_reg <= 1'b0;
    end else if (pre_reg == MS_CYCLES - 1) begin
      pre_reg <= 28'h0000000;
      ms_tick_reg <= 1'b1; // RL19
    end else begin
      pre_reg <= pre_reg + 28'h0000001;
      ms_tick_reg <= 1'b0;
    end
  end

  // Debounce: level must stand for the debounce time before it counts
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_db
      always @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
          db_cnt_reg[gi] <= 18'h00000;
          btn_reg[gi] <= 1'b0;
        end else if (pin_s2_reg[gi] == btn_reg[gi]) begin
          db_cnt_reg[gi] <= 18'h00000;
        end else if (ms_tick_reg) begin
          if (db_cnt_reg[gi] == `PBL_DEBOUNCE_MS - 1) begin
            btn_reg[gi] <= pin_s2_reg[gi]; // RL19
            db_cnt_reg[gi] <= 18'h00000;
          end else begin
            db_cnt_reg[gi] <= db_cnt_reg[gi] + 18'h00001;
          end
        end
      end
    end
  endgenerate

  assign any_btn = |btn_reg;
  // Button chosen at initiation; confirm must match it
  assign sel_btn = armed_btn_reg ? btn_reg[0] : btn_reg[1];

  // Twinkle restarts lit on entry, so a short confirm window never misses it
  always @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      blink_reg <= 7'h00;
      tw_reg <= 1'b1;
    end else if (state_reg != S_WAIT && state_reg != S_CONF) begin
      blink_reg <= 7'h00;
      tw_reg <= 1'b1;
    end else if (ms_tick_reg) begin
      if (blink_reg == `PBL_TWINKLE_MS - 1) begin
        blink_reg <= 7'h00;
        tw_reg <= ~tw_reg; // RL3
      end else begin
        blink_reg <= blink_reg + 7'h01;
      end
    end
  end

  // Main sequencer; ms_cnt_reg times every stage but idle, transfer and release
  always @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_PWR1;
      ms_cnt_reg <= 14'h0000;
      step_reg <= 3'h0;
      dir_save_reg <= 1'b0;
      armed_btn_reg <= 1'b0;
      strap_done_reg <= 1'b0;
      recovery_mode_out <= 1'b0;
      laser_on_out <= 1'b1;
      xfer_start_out <= 1'b0;
      xfer_save_out <= 1'b0;
      q_good_reg <= 1'b0;
    end else begin
      xfer_start_out <= 1'b0;
      if (ms_tick_reg && ms_cnt_reg != 14'h3FFF)
        ms_cnt_reg <= ms_cnt_reg + 14'h0001;
      // Strap caught after synchroniser and debounce settle
      if (!strap_done_reg && state_reg == S_PWR1 && ms_cnt_reg == `PBL_DEBOUNCE_MS * 2) begin
        strap_done_reg <= 1'b1;
        recovery_mode_out <= btn_reg[2]; // RL16
      end
      case (state_reg)
        S_PWR1: begin
          if (ms_cnt_reg >= `PBL_PWR_FIRST_MS) begin
            state_reg <= S_PWR2; // RL1
            ms_cnt_reg <= 14'h0000;
          end
        end
        S_PWR2: begin
          if (ms_cnt_reg >= `PBL_PWR_ALL_MS && !any_btn) begin
            state_reg <= S_IDLE; // RL1
            ms_cnt_reg <= 14'h0000;
          end
        end
        S_IDLE: begin
          ms_cnt_reg <= 14'h0000;
          if (buttons_enable_in && any_btn) begin // RL15
            state_reg <= btn_reg[2] ? S_LASER : S_HOLD;
            armed_btn_reg <= btn_reg[0];
            dir_save_reg <= btn_reg[0]; // RL14
          end else if (package_done_in && !no_dimension_result_in) begin
            state_reg <= S_QFLASH; // RL2
            q_good_reg <= quality_good_in;
          end
        end
        S_QFLASH: begin
          if (ms_cnt_reg >= `PBL_QFLASH_MS)
            state_reg <= S_IDLE;
        end
        S_HOLD: begin
          if (!sel_btn) begin
            // Arm only after a long hold is released
            state_reg <= (ms_cnt_reg >= `PBL_HOLD_MS && buttons_enable_in) ? S_WAIT : S_IDLE; // RL10
            ms_cnt_reg <= 14'h0000;
          end
        end
        S_WAIT: begin
          if (!buttons_enable_in || ms_cnt_reg >= CONFIRM_TMO_MS) begin
            state_reg <= S_IDLE; // RL18
          end else if (sel_btn) begin
            state_reg <= S_CONF; // RL3
            ms_cnt_reg <= 14'h0000;
          end
        end
        S_CONF: begin
          if (!sel_btn) begin
            ms_cnt_reg <= 14'h0000;
            step_reg <= 3'h0;
            // Long second press is no confirm; start over
            state_reg <= (ms_cnt_reg < `PBL_HOLD_MS) ? S_SWEEP : S_IDLE; // RL11 RL12
          end
        end
        S_SWEEP: begin
          if (!buttons_enable_in) begin
            state_reg <= S_IDLE; // RL15
          end else if (ms_cnt_reg >= `PBL_STEP_MS) begin
            ms_cnt_reg <= 14'h0000;
            if (step_reg == 3'd4) begin
              state_reg <= S_XFER;
              xfer_start_out <= 1'b1;
              xfer_save_out <= dir_save_reg; // RL14
            end else begin
              step_reg <= step_reg + 3'h1; // RL4
            end
          end
        end
        S_XFER: begin
          if (xfer_done_in) begin
            state_reg <= xfer_ok_in ? S_OK : S_FAIL;
            ms_cnt_reg <= 14'h0000;
          end
        end
        S_OK, S_FAIL: begin
          if (ms_cnt_reg >= `PBL_RESULT_MS)
            state_reg <= S_IDLE; // RL6 RL7
        end
        S_LASER: begin
          if (!btn_reg[2]) begin
            state_reg <= S_IDLE;
          end else if (ms_cnt_reg >= `PBL_LASER_HOLD_MS) begin
            laser_on_out <= ~laser_on_out; // RL9
            state_reg <= S_REL;
          end
        end
        S_REL: begin
          // Lamps dark until every button is let go, so one hold toggles once
          if (!any_btn)
            state_reg <= S_IDLE; // RL9
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // Slow firmware blink counter, separate so the fast one stays short
  always @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      fw_cnt_reg <= 9'h000;
      fw_blink_reg <= 1'b0;
    end else if (ms_tick_reg) begin
      if (fw_cnt_reg == `PBL_FW_BLINK_MS - 1) begin
        fw_cnt_reg <= 9'h000;
        fw_blink_reg <= ~fw_blink_reg; // RL8
      end else begin
        fw_cnt_reg <= fw_cnt_reg + 9'h001;
      end
    end
  end

  // Lamp pattern per state; registered so the pins never glitch
  always @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      bar_led_out <= `PBL_LED_OFF;
      led_green_out <= 1'b0;
      led_red_out <= 1'b0;
      led_yellow_out <= 1'b0;
    end else begin
      led_green_out <= !fw_update_in && (state_reg == S_OK || (state_reg == S_QFLASH && q_good_reg)); // RL6
      led_red_out <= !fw_update_in && (state_reg == S_FAIL || (state_reg == S_QFLASH && !q_good_reg)); // RL7
      led_yellow_out <= !fw_update_in && state_reg == S_XFER && xfer_busy_in; // RL5
      if (fw_update_in) begin
        bar_led_out <= `PBL_LED_1245 | (fw_blink_reg ? `PBL_LED_3 : `PBL_LED_OFF); // RL8
      end else begin
        case (state_reg)
          S_PWR1: bar_led_out <= `PBL_LED_135; // RL1
          S_PWR2: bar_led_out <= `PBL_LED_ALL; // RL1
          S_WAIT, S_CONF: bar_led_out <= tw_reg ? `PBL_LED_ALL : `PBL_LED_OFF; // RL3
          S_SWEEP: begin
            bar_led_out <= dir_save_reg ? `PBL_LED_SWEEP_TOP >> step_reg : `PBL_LED_SWEEP_BOT << step_reg; // RL4
          end
          S_XFER: bar_led_out <= `PBL_LED_3; // RL5
          S_OK: bar_led_out <= `PBL_LED_45; // RL6
          S_FAIL: bar_led_out <= `PBL_LED_12; // RL7
          S_QFLASH: bar_led_out <= q_good_reg ? `PBL_LED_45 : `PBL_LED_12; // RL2
          S_LASER: bar_led_out <= `PBL_LED_ALL; // RL9
          default: bar_led_out <= `PBL_LED_OFF;
        endcase
      end
    end
  end
endmodule

/* File: tb/pbl_seq_sva.sv */
// Purpose: Port assertions for the LED sequencer
// Assumes: One clock domain
// Notes: Bound below
`timescale 1ns/100ps
module pbl_seq_sva (
  input wire sys_clk_in,
  input wire reset_n_in,
  input wire buttons_enable_in,
  input wire fw_update_in,
  input wire [4:0] bar_led_out,
  input wire led_green_out,
  input wire led_red_out,
  input wire led_yellow_out,
  input wire xfer_start_out,
  input wire laser_on_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  // Lamp patterns tied to colour outputs
  yellow_only_a: assert property (led_yellow_out |-> bar_led_out == 5'h04) else $error("yellow");
  green_pair_a: assert property (led_green_out |-> bar_led_out == 5'h18) else $error("green");
  red_pair_a: assert property (led_red_out |-> bar_led_out == 5'h03) else $error("red");
  result_excl_a: assert property (!(led_green_out && led_red_out)) else $error("both");
  yellow_excl_a: assert property (led_yellow_out |-> !led_green_out && !led_red_out) else $error("mix");
  // Starts only with panel enabled
  start_enabled_a: assert property ($rose(xfer_start_out) |-> $past(buttons_enable_in)) else $error("start");
  fw_pattern_a: assert property (fw_update_in [*8] |-> (bar_led_out & 5'h1B) == 5'h1B) else $error("fw");
  laser_dark_a: assert property ($changed(laser_on_out) |-> ##[0:4] bar_led_out == 5'h00) else $error("dark");
  cover property ($rose(led_green_out));
  cover property ($rose(led_red_out));
  cover property ($changed(laser_on_out));
endmodule
bind pbl_sequencer pbl_seq_sva chk (.sys_clk_in, .reset_n_in, .buttons_enable_in, .fw_update_in, .bar_led_out,
  .led_green_out, .led_red_out, .led_yellow_out, .xfer_start_out, .laser_on_out);

/* File: tb/pbl_backup_model.sv */
// Purpose: Behavioural parameter backup module
// Assumes: Shares the system clock
// Notes: ok is only valid with done
`timescale 1ns/100ps
module pbl_backup_model (
  input wire clk_in,
  input wire reset_n_in,
  input wire start_in,
  input wire save_in,
  input wire locked_in,
  input wire [7:0] delay_in,
  output reg busy_out,
  output reg done_out,
  output reg ok_out
);
  reg [7:0] cnt_reg;
  reg save_reg;
  // Busy for delay cycles, then a done pulse
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      busy_out <= 1'b0;
      done_out <= 1'b0;
      ok_out <= 1'b0;
      cnt_reg <= 8'h00;
      save_reg <= 1'b0;
    end else begin
      done_out <= 1'b0;
      ok_out <= ~ok_out; // Garbage outside done
      if (start_in && !busy_out) begin
        busy_out <= 1'b1;
        cnt_reg <= delay_in;
        save_reg <= save_in;
      end else if (busy_out) begin
        cnt_reg <= cnt_reg - 8'h01;
        if (cnt_reg == 8'h01) begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
          ok_out <= !(save_reg && locked_in);
        end
      end
    end
  end
endmodule

/* File: tb/test_panel_button_led_sequencer.sv */
// Purpose: Self-checking bench for the LED sequencer
// Assumes: MS_CYCLES of 4 shortens all times
// Notes: Inputs change on falling edges
`timescale 1ns/100ps
module test_panel_button_led_sequencer;
  reg clk = 0, rst_n = 0, dn = 0, up = 0, las = 0, en = 1, fw = 0, wp = 0, last_save = 0;
  reg pkg = 0, nod = 0, qg = 0;
  reg [7:0] dly = 8'h40;
  wire [4:0] bar;
  wire g, r, y, st, sv, lon, rec, busy, done, ok;
  integer err_count = 0, compares = 0, starts = 0;
  always #2 clk = ~clk;
  pbl_sequencer #(.CONFIRM_TMO_MS(100), .MS_CYCLES(4)) uut (.sys_clk_in(clk), .reset_n_in(rst_n),
    .btn_down_in(dn), .btn_up_in(up), .btn_laser_in(las), .buttons_enable_in(en), .package_done_in(pkg),
    .no_dimension_result_in(nod), .quality_good_in(qg), .fw_update_in(fw), .xfer_busy_in(busy),
    .xfer_done_in(done), .xfer_ok_in(ok), .bar_led_out(bar), .led_green_out(g), .led_red_out(r),
    .led_yellow_out(y), .xfer_start_out(st), .xfer_save_out(sv), .laser_on_out(lon), .recovery_mode_out(rec));
  pbl_backup_model bm (.clk_in(clk), .reset_n_in(rst_n), .start_in(st), .save_in(sv), .locked_in(wp),
    .delay_in(dly), .busy_out(busy), .done_out(done), .ok_out(ok));
  // Count transfer starts and note direction
  always @(posedge clk) if (st === 1'b1) begin starts <= starts + 1; last_save <= sv; end
  task chk(input [4:0] e, input [4:0] a); begin
    compares = compares + 1;
    if (a !== e) begin err_count = err_count + 1; $display("BAD t=%0t exp=%h got=%h", $time, e, a); end
  end endtask
  task cyc(input integer n); repeat (n) @(negedge clk); endtask
  task wled(input [4:0] v, input integer lim); integer i; begin
    i = 0;
    while (bar !== v && i < lim) begin @(negedge clk); i = i + 1; end
    chk(v, bar);
  end endtask
  task push(input integer b, input integer ms); begin
    dn = (b == 0); up = (b == 1); las = (b == 2); cyc(ms * 4); dn = 0; up = 0; las = 0;
  end endtask
  // Long press, release, then no confirm
  task t_lone; integer k, n; begin
    k = starts; dn = 1; cyc(4800);
    chk(5'h00, bar);
    dn = 0;
    wled(5'h1F, 2000);
    cyc(2000); n = 0;
    repeat (500) begin @(negedge clk); n = n | bar; end
    chk(5'h00, n[4:0]);
    chk(5'h00, {4'h0, starts != k});
  end endtask
  task t_off; integer k; begin
    k = starts; en = 0; push(0, 1200); cyc(400); push(0, 300); cyc(2000);
    chk(5'h00, {4'h0, starts != k});
    en = 1;
  end endtask
  // Initiate, confirm, sweep, transfer, result
  task t_xfer(input s, input lk); begin
    wp = lk; dly = s ? 8'hC0 : 8'h08; push(s ? 0 : 1, 1200);
    wled(5'h1F, 2000);
    fork push(s ? 0 : 1, 300); join_none
    wled(s ? 5'h10 : 5'h01, 3000);
    wled(s ? 5'h01 : 5'h10, 5000);
    wled(5'h04, 3000);
    chk({4'h0, s}, {4'h0, last_save});
    wled(lk ? 5'h03 : 5'h18, 3000);
    cyc(7000); chk(lk ? 5'h03 : 5'h18, bar);
    cyc(2000); chk(5'h00, bar);
  end endtask
  task t_laser; reg k; begin
    k = lon; fork push(2, 5200); join_none
    cyc(4000); chk(5'h1F, bar);
    cyc(18000); chk({4'h0, !k}, {4'h0, lon});
    chk(5'h00, bar);
  end endtask
  // Firmware pattern: four steady, LED 3 seen both lit and dark
  task t_fw; integer n, m; begin
    fw = 1; cyc(16); chk(5'h1B, bar & 5'h1B);
    n = 0; m = 5'h1F;
    repeat (2400) begin @(negedge clk); n = n | bar; m = m & bar; end
    chk(5'h1F, n[4:0]);
    chk(5'h1B, m[4:0]);
    fw = 0; cyc(10);
  end endtask
  // Quality flash: good, then no-dimension, then bad
  task t_q; integer n; begin
    pkg = 1; qg = 1; cyc(1); pkg = 0;
    wled(5'h18, 10);
    cyc(600); chk(5'h00, bar);
    pkg = 1; qg = 0; nod = 1; cyc(1); pkg = 0; nod = 0; n = 0;
    repeat (600) begin @(negedge clk); n = n | bar; end
    chk(5'h00, n[4:0]);
    pkg = 1; cyc(1); pkg = 0;
    wled(5'h03, 10);
    cyc(600); chk(5'h00, bar);
  end endtask
  // Mid-run power cycle with the laser button held
  task t_rec; begin
    las = 1; rst_n = 0; cyc(2); rst_n = 1; cyc(400);
    chk(5'h01, {4'h0, rec});
    chk(5'h15, bar);
    las = 0;
  end endtask
  task wrap_up; begin
    $display("err_count=%0d compares=%0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  end endtask
  initial begin
    cyc(2); rst_n = 1;
    wled(5'h15, 8000);
    wled(5'h1F, 8000);
    chk(5'h00, {4'h0, rec});
    wled(5'h00, 8000);
    t_lone;
    t_off;
    t_q;
    t_xfer(1, 1);
    t_xfer(0, 0);
    t_laser;
    t_fw;
    t_rec;
    wrap_up;
  end
  initial begin cyc(96000); err_count = err_count + 1; wrap_up; end
endmodule
